// File: core_seg_model.sv
// core segment register model: live FS and GS as the core's register file holds them
// assumes load pulses from the checker last one core_clk cycle
`timescale 1ns/1ps
`default_nettype none
module core_seg_model #(
	parameter logic [63:0] INIT_FS = 64'h0000_7f00_1234_5000,
	parameter logic [63:0] INIT_GS = 64'h0000_7f00_5678_9000
) (
	input wire logic core_clk, // core clock
	input wire logic rst, // sync reset
	input wire logic segLoad, // load pulse
	input wire logic [63:0] fsOut, // FS to load
	input wire logic [63:0] gsOut, // GS to load
	output var logic [63:0] fsIn, // live FS
	output var logic [63:0] gsIn // live GS
);
	always @(posedge core_clk) begin
		if (rst) begin
			fsIn <= INIT_FS;
			gsIn <= INIT_GS;
		end else if (segLoad) begin
			fsIn <= fsOut;
			gsIn <= gsOut;
		end
	end
endmodule
`default_nettype wire

// File: enclave_access_checker.v
// enclave access checker: section enumeration, access checks, mode and FS/GS swap
// assumes the core presents one access per valid cycle with translation and map
// attributes already looked up, and segment limit checks done upstream
// Operation
// - invalid sub-leaf returns all four words zero
// - type 0001b marks a section; word0 bits 11:4 read zero
// - base 31:12 in word0 31:12, base 51:32 in word1 19:0
// - valid section: word2 3:0 = 0001b; invalid: word2, word3 zero
// - size 31:12 in word2 31:12, size 51:32 in word3 19:0
// - enclave access in linear range not mapping protected page faults
// - enter only by enter/resume, leave only by leave/async exit
// - non-enclave access to protected page: reads all ones, writes dropped
// - enclave fetch outside linear range gives general protection fault zero
// - regular/thread/trimmed pages only at allocated linear address, else page fault
// - direct access checked against map; page must belong to running enclave
// - write, read, fetch need matching map permission
// - reject restricted types: control, thread, version array, trimmed
// - reject blocked, pending or modified pages
// - normal segmentation checks apply to all accesses unchanged
// - enter/resume needs zero base on usable CS, DS, ES, SS
// - enter/resume saves outside FS/GS; enter loads thread structure values, resume loads save area values
// - exits restore FS/GS; async exit saves enclave FS/GS to save area
// - classify direct, indirect, non-enclave accesses
`include "enclave_access_checker_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module enclave_access_checker (
	input wire core_clk, // core clock
	input wire rst, // synchronous reset, active high
	// enumeration
	input wire queryValid, // feature query request
	input wire [31:0] queryIndex, // sub-leaf index
	input wire [51:0] sectionBase, // section physical base (strap)
	input wire [51:0] sectionSize, // section size (strap)
	input wire sectionPresent, // a section is configured (strap)
	output reg [31:0] section_info_word0, // answer word 0
	output reg [31:0] section_info_word1, // answer word 1
	output reg [31:0] section_info_word2, // answer word 2
	output reg [31:0] section_info_word3, // answer word 3
	output reg queryDone, // answer valid pulse
	// mode control
	input wire [2:0] modeOp, // enter/resume/leave/async exit request
	input wire [3:0] segUsable, // usable CS, DS, ES, SS
	input wire [3:0] segBaseNonZero, // non-zero base CS, DS, ES, SS
	input wire [63:0] fsIn, // current FS
	input wire [63:0] gsIn, // current GS
	input wire [63:0] tcsFs, // FS from thread control structure
	input wire [63:0] tcsGs, // GS from thread control structure
	input wire [63:0] ssaFs, // FS from state save area
	input wire [63:0] ssaGs, // GS from state save area
	output reg [63:0] fsOut, // FS value to load
	output reg [63:0] gsOut, // GS value to load
	output reg segLoad, // load fsOut/gsOut pulse
	output reg [63:0] ssaFsOut, // FS to store in save area
	output reg [63:0] ssaGsOut, // GS to store in save area
	output reg ssaStore, // store to save area pulse
	output reg modeFault, // general protection fault on entry
	output reg inEnclave, // enclave mode flag
	// access check
	input wire accValid, // access request
	input wire [1:0] accKind, // read, write or fetch
	input wire accIndirect, // access issued by an enclave leaf operation
	input wire [51:0] accLinear, // linear address
	input wire segFault, // segmentation check failed
	input wire [51:0] rangeBase, // enclave linear range base
	input wire [51:0] rangeLimit, // enclave linear range last byte
	input wire mapsProtected, // translation hits a protected page
	input wire [2:0] mapType, // page type from map
	input wire mapR, // map read permission
	input wire mapW, // map write permission
	input wire mapX, // map execute permission
	input wire mapOwnerMatch, // page belongs to running enclave
	input wire mapLinearMatch, // allocation linear address matches
	input wire mapBlocked, // page blocked
	input wire mapPending, // page pending
	input wire mapModified, // page modified
	output reg accDone, // result valid pulse
	output reg [1:0] faultType, // fault kind
	output reg [15:0] faultCode, // general protection error code
	output reg faultEnclaveFlag, // page fault enclave flag
	output reg [1:0] accClass, // access classification
	output reg suppress, // drop memory operation
	output reg forceOnes // return all ones for read
);

	reg [51:0] cfgBase;
	reg [51:0] cfgSize;
	reg cfgPresent;
	reg cfgCaught;
	reg [63:0] savedFs;
	reg [63:0] savedGs;
	reg next_inEnclave;
	reg [1:0] next_faultType;
	reg next_faultEnclaveFlag;
	reg next_suppress;
	reg next_forceOnes;
	reg [1:0] next_accClass;
	wire inRange;
	wire restrictedType;
	wire permOk;
	wire sectionHit;
	wire enterReq;
	wire exitReq;
	wire entryBaseBad;
	wire fromSaveArea;
	wire entryOk;
	wire exitOk;
	wire asyncExit;
	wire directAcc;
	wire fetchEscape;
	wire aliasType;
	wire aliasFault;
	wire mapCheckFail;
	wire stateFail;
	wire outsideProtected;

	// straps caught once after reset release so answers never change
	always @(posedge core_clk) begin
		if (rst) begin
			cfgCaught <= 1'b0;
			cfgBase <= `ZERO52;
			cfgSize <= `ZERO52;
			cfgPresent <= 1'b0;
		end else if (!cfgCaught) begin
			cfgCaught <= 1'b1;
			cfgBase <= sectionBase;
			cfgSize <= sectionSize;
			cfgPresent <= sectionPresent;
		end
	end

	// only one section is modelled, at the first scanned index
	assign sectionHit = cfgPresent && (queryIndex == `FIRST_SECTION_INDEX);

	always @(posedge core_clk) begin
		if (rst) begin
			section_info_word0 <= `ZERO32;
			section_info_word1 <= `ZERO32;
			section_info_word2 <= `ZERO32;
			section_info_word3 <= `ZERO32;
			queryDone <= 1'b0;
		end else begin
			queryDone <= queryValid;
			if (queryValid) begin
				if (sectionHit) begin
					section_info_word0 <= {cfgBase[31:12], `ZERO8, `SUBLEAF_TYPE_SECTION};
					section_info_word1 <= {`ZERO12, cfgBase[51:32]};
					section_info_word2 <= {cfgSize[31:12], `ZERO8, `SECTION_PROT_CI};
					section_info_word3 <= {`ZERO12, cfgSize[51:32]};
				end else begin
					section_info_word0 <= {`ZERO32};
					section_info_word1 <= `ZERO32;
					section_info_word2 <= `ZERO32;
					section_info_word3 <= `ZERO32;
				end
			end
		end
	end

	// requests that arrive in the wrong mode are ignored, not faulted
	assign enterReq = (modeOp == `OP_ENTER) || (modeOp == `OP_RESUME);
	assign exitReq = (modeOp == `OP_LEAVE) || (modeOp == `OP_ASYNC_EXIT);
	assign entryBaseBad = |(segUsable & segBaseNonZero);
	assign fromSaveArea = (modeOp == `OP_RESUME);
	assign entryOk = !inEnclave && enterReq && !entryBaseBad;
	assign exitOk = inEnclave && exitReq;
	assign asyncExit = exitOk && (modeOp == `OP_ASYNC_EXIT);

	// mode transitions: only the documented operations change the flag
	always @* begin
		next_inEnclave = inEnclave;
		case (inEnclave)
			`ST_OUTSIDE: begin
				if (entryOk)
					next_inEnclave = `ST_INSIDE;
			end
			`ST_INSIDE: begin
				if (exitOk)
					next_inEnclave = `ST_OUTSIDE;
			end
			default: next_inEnclave = `ST_OUTSIDE;
		endcase
	end

	// mode flag and the outside FS/GS kept for the way back
	always @(posedge core_clk) begin
		if (rst) begin
			inEnclave <= `ST_OUTSIDE;
			savedFs <= `ZERO64;
			savedGs <= `ZERO64;
		end else begin
			inEnclave <= next_inEnclave;
			if (entryOk) begin
				savedFs <= fsIn;
				savedGs <= gsIn;
			end
		end
	end

	// values the core loads into FS/GS; a refused entry loads nothing
	always @(posedge core_clk) begin
		if (rst) begin
			fsOut <= `ZERO64;
			gsOut <= `ZERO64;
			segLoad <= 1'b0;
			modeFault <= 1'b0;
		end else begin
			segLoad <= entryOk || exitOk;
			modeFault <= !inEnclave && enterReq && entryBaseBad;
			if (entryOk) begin
				fsOut <= fromSaveArea ? ssaFs : tcsFs;
				gsOut <= fromSaveArea ? ssaGs : tcsGs;
			end else if (exitOk) begin
				fsOut <= savedFs;
				gsOut <= savedGs;
			end
		end
	end

	// enclave values are the live FS/GS while inside, so those go to the save area
	always @(posedge core_clk) begin
		if (rst) begin
			ssaFsOut <= `ZERO64;
			ssaGsOut <= `ZERO64;
			ssaStore <= 1'b0;
		end else begin
			ssaStore <= asyncExit;
			if (asyncExit) begin
				ssaFsOut <= fsIn;
				ssaGsOut <= gsIn;
			end
		end
	end

	assign inRange = (accLinear >= rangeBase) && (accLinear <= rangeLimit);
	assign restrictedType = (mapType == `PAGE_TYPE_ENCLAVE_CONTROL) ||
		(mapType == `PAGE_TYPE_THREAD_CONTROL) ||
		(mapType == `PAGE_TYPE_VERSION_ARRAY) ||
		(mapType == `PAGE_TYPE_TRIMMED);
	assign permOk = (accKind == `ACC_WRITE) ? mapW :
		(accKind == `ACC_FETCH) ? mapX : mapR;
	assign directAcc = inEnclave && !accIndirect && inRange;
	// a fetch leaving the range is refused even when it hits ordinary memory
	assign fetchEscape = inEnclave && !accIndirect && !inRange && (accKind == `ACC_FETCH);
	assign aliasType = (mapType == `PAGE_TYPE_REGULAR) ||
		(mapType == `PAGE_TYPE_THREAD_CONTROL) ||
		(mapType == `PAGE_TYPE_TRIMMED);
	assign aliasFault = aliasType && !mapLinearMatch;
	assign mapCheckFail = !mapOwnerMatch || !permOk || restrictedType;
	assign stateFail = mapBlocked || mapPending || mapModified;
	assign outsideProtected = !directAcc && !accIndirect && mapsProtected;

	// priority: segmentation, fetch escape, mapping, alias, map attributes
	always @* begin
		next_accClass = `CLASS_NON_ENCLAVE;
		next_faultType = `FAULT_NONE;
		next_faultEnclaveFlag = 1'b0;
		next_suppress = 1'b0;
		next_forceOnes = 1'b0;
		if (accValid) begin
			if (accIndirect)
				next_accClass = `CLASS_INDIRECT;
			else if (directAcc)
				next_accClass = `CLASS_DIRECT;
			// one fault at most: the first failing check wins
			if (segFault) begin
				next_faultType = `FAULT_SEGMENT;
				next_suppress = 1'b1;
			end else if (fetchEscape) begin
				next_faultType = `FAULT_GENERAL_PROTECTION;
				next_suppress = 1'b1;
			end else if (directAcc) begin
				if (!mapsProtected) begin
					next_faultType = `FAULT_PAGE;
					next_suppress = 1'b1;
				end else if (aliasFault || mapCheckFail || stateFail) begin
					next_faultType = `FAULT_PAGE;
					next_faultEnclaveFlag = 1'b1;
					next_suppress = 1'b1;
				end
			end else if (outsideProtected) begin
				// no fault: the access is altered instead, to hide enclave data
				next_suppress = 1'b1;
				next_forceOnes = (accKind != `ACC_WRITE);
			end
		end
	end

	// results stand for one cycle beside accDone and are zero otherwise
	always @(posedge core_clk) begin
		if (rst) begin
			accDone <= 1'b0;
			faultType <= `FAULT_NONE;
			faultCode <= `ZERO16;
			faultEnclaveFlag <= 1'b0;
			accClass <= `CLASS_NON_ENCLAVE;
			suppress <= 1'b0;
			forceOnes <= 1'b0;
		end else begin
			accDone <= accValid;
			faultType <= next_faultType;
			faultCode <= `ZERO16;
			faultEnclaveFlag <= next_faultEnclaveFlag;
			accClass <= next_accClass;
			suppress <= next_suppress;
			forceOnes <= next_forceOnes;
		end
	end

endmodule

`default_nettype wire

// File: enclave_access_checker_chk.sv
// assertions on the enclave access checker ports
// bound into every instance of the checker block
`timescale 1ns/1ps
`default_nettype none
module enclave_access_checker_chk (
	input wire logic core_clk, rst, queryValid, sectionPresent, queryDone, segLoad, // ctl
	input wire logic ssaStore, modeFault, inEnclave, accValid, accIndirect, segFault, // ctl
	input wire logic mapsProtected, accDone, suppress, forceOnes, // ctl
	input wire logic [31:0] queryIndex, section_info_word0, section_info_word1, // words
	input wire logic [31:0] section_info_word2, section_info_word3, // words
	input wire logic [2:0] modeOp, // mode op
	input wire logic [3:0] segUsable, segBaseNonZero, // segments
	input wire logic [63:0] tcsFs, fsIn, fsOut, ssaFsOut, // FS values
	input wire logic [1:0] accKind, faultType, // access
	input wire logic [51:0] accLinear, rangeBase, rangeLimit, // addresses
	input wire logic [15:0] faultCode // error code
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	invalid_zero_a: assert property (queryValid && (queryIndex != 2 || !sectionPresent) |=>
		{section_info_word3, section_info_word2, section_info_word1, section_info_word0} == 0)
		else $error("invalid sub-leaf words not zero");
	section_type_a: assert property (queryValid && queryIndex == 2 && sectionPresent |=>
		section_info_word0[11:0] == 12'h001 && section_info_word2[11:0] == 12'h001)
		else $error("section type or protection field wrong");
	fetch_gp_a: assert property (accValid && accKind == 2'h2 && inEnclave && !segFault
		&& !accIndirect && (accLinear < rangeBase || accLinear > rangeLimit) |=>
		faultType == 2'h1 && faultCode == 16'h0000 && suppress) else $error("fetch out not GP");
	fault_suppress_a: assert property (faultType != 2'h0 |-> accDone && suppress)
		else $error("fault without suppress");
	entry_base_a: assert property (modeOp == 3'h1 && !inEnclave && |(segUsable & segBaseNonZero)
		|=> modeFault && !inEnclave) else $error("bad base entry not refused");
	entry_swap_a: assert property (modeOp == 3'h1 && !inEnclave
		&& !(|(segUsable & segBaseNonZero)) |=> segLoad && inEnclave && fsOut == $past(tcsFs))
		else $error("entry FS load wrong");
	mode_enter_a: assert property ($rose(inEnclave) |-> $past(modeOp) inside {3'h1, 3'h2})
		else $error("enclave mode entered without enter op");
	mode_leave_a: assert property ($fell(inEnclave) |-> $past(modeOp) inside {3'h3, 3'h4} || $past(rst))
		else $error("enclave mode left without exit op");
	async_save_a: assert property (modeOp == 3'h4 && inEnclave |=>
		ssaStore && ssaFsOut == $past(fsIn) && !inEnclave) else $error("async exit save wrong");
	outside_ones_a: assert property (accValid && !inEnclave && mapsProtected && accKind == 2'h0
		&& !segFault && !accIndirect |=> suppress && forceOnes && faultType == 2'h0)
		else $error("outside read");
	cover property (accDone && faultType == 2'h2);
	cover property (modeFault);
	cover property (ssaStore);
endmodule
bind enclave_access_checker enclave_access_checker_chk enclave_access_checker_chk_i (.*);
`default_nettype wire

// File: enclave_access_checker_defines.vh
// constants for the enclave access checker: fault kinds, page types, field values
// included by enclave_access_checker.v only
`ifndef ENCLAVE_ACCESS_CHECKER_DEFINES_VH
`define ENCLAVE_ACCESS_CHECKER_DEFINES_VH

`define SUBLEAF_TYPE_INVALID 4'h0
`define SUBLEAF_TYPE_SECTION 4'h1
`define SECTION_PROT_CI 4'h1
`define FIRST_SECTION_INDEX 32'h00000002
`define ZERO8 8'h00
`define ZERO12 12'h000
`define ZERO32 32'h00000000
`define ZERO16 16'h0000
`define ZERO52 52'h0000000000000
`define ZERO64 64'h0000000000000000

`define PAGE_TYPE_ENCLAVE_CONTROL 3'h0
`define PAGE_TYPE_THREAD_CONTROL 3'h1
`define PAGE_TYPE_REGULAR 3'h2
`define PAGE_TYPE_VERSION_ARRAY 3'h3
`define PAGE_TYPE_TRIMMED 3'h4

`define FAULT_NONE 2'h0
`define FAULT_GENERAL_PROTECTION 2'h1
`define FAULT_PAGE 2'h2
`define FAULT_SEGMENT 2'h3

`define ACC_READ 2'h0
`define ACC_WRITE 2'h1
`define ACC_FETCH 2'h2

`define CLASS_NON_ENCLAVE 2'h0
`define CLASS_DIRECT 2'h1
`define CLASS_INDIRECT 2'h2

`define OP_NONE 3'h0
`define OP_ENTER 3'h1
`define OP_RESUME 3'h2
`define OP_LEAVE 3'h3
`define OP_ASYNC_EXIT 3'h4

`define ST_OUTSIDE 1'b0
`define ST_INSIDE 1'b1

`define ALL_ONES64 64'hffffffffffffffff

`endif

// File: enclave_access_checker_tb.sv
// self-checking bench for the enclave access checker, random straps and accesses
// the segment model stands for the core's FS/GS register file
`timescale 1ns/1ps
`default_nettype none
module enclave_access_checker_tb;
	localparam logic [63:0] OFS = 64'h0000_7f00_1234_5000;
	localparam logic [63:0] OGS = 64'h0000_7f00_5678_9000;
	logic core_clk = 0, rst = 1, queryValid = 0, sectionPresent = 1, accValid = 0, accIndirect = 0;
	logic segFault = 0, mapsProtected = 0, mapR = 0, mapW = 0, mapX = 0, mapOwnerMatch = 1;
	logic mapLinearMatch = 1, mapBlocked = 0, mapPending = 0, mapModified = 0, ins = 0;
	logic [31:0] queryIndex = 0;
	logic [51:0] sectionBase, sectionSize, accLinear = 0, rangeBase = 52'h1000;
	logic [51:0] rangeLimit = 52'h8fff;
	logic [2:0] modeOp = 0, mapType = 2;
	logic [3:0] segUsable = 4'hf, segBaseNonZero = 0;
	logic [1:0] accKind = 0;
	logic [63:0] tcsFs, tcsGs, ssaFs, ssaGs;
	wire [63:0] fsIn, gsIn, fsOut, gsOut, ssaFsOut, ssaGsOut;
	wire [31:0] section_info_word0, section_info_word1, section_info_word2, section_info_word3;
	wire queryDone, segLoad, ssaStore, modeFault, inEnclave, accDone, faultEnclaveFlag;
	wire suppress, forceOnes;
	wire [1:0] faultType, accClass;
	wire [15:0] faultCode;
	int num_errors = 0, num_checks = 0, cyc = 0;
	enclave_access_checker enclave_access_checker_i (.*);
	core_seg_model #(.INIT_FS(OFS), .INIT_GS(OGS)) core_seg_model_i (
		.core_clk(core_clk),
		.rst(rst),
		.segLoad(segLoad),
		.fsOut(fsOut),
		.gsOut(gsOut),
		.fsIn(fsIn),
		.gsIn(gsIn)
	);
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc > 2000) begin
		num_errors++;
		end_sim;
	end
	task automatic ck(input string n, input logic [127:0] e, input logic [127:0] s);
		num_checks++;
		if (e !== s) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [127:0] expw(input logic [31:0] i);
		expw = (i == 2 && sectionPresent) ? {sectionSize[51:12], 12'h001, sectionBase[51:32],
			sectionBase[31:12], 12'h001} : '0;
	endfunction
	task automatic qry(input logic [31:0] i);
		@(posedge core_clk) #1 queryValid = 1;
		queryIndex = i;
		@(posedge core_clk) #1 queryValid = 0;
		ck("qdone", 1, queryDone);
		ck("words", expw(i), {section_info_word3[19:0], section_info_word2,
			section_info_word1[19:0], section_info_word0});
	endtask
	task automatic acc(input logic [1:0] k, input logic [51:0] a, input logic [1:0] ft, input logic fl);
		@(posedge core_clk) #1 accValid = 1;
		accKind = k;
		accLinear = a;
		@(posedge core_clk) #1 accValid = 0;
		ck("adone", 1, accDone);
		ck("code", 0, faultCode);
		ck("faultType", ft, faultType);
		ck("flag", fl, faultEnclaveFlag);
		ck("suppress", ft != 0 || !ins, suppress);
	endtask
	task automatic mode(input logic [2:0] op);
		@(posedge core_clk) #1 modeOp = op;
		@(posedge core_clk) #1 modeOp = 0;
	endtask
	task end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		void'($urandom(86477));
		sectionBase = 52'({$urandom(), $urandom()});
		sectionSize = 52'({$urandom(), $urandom()});
		{tcsFs, tcsGs, ssaFs, ssaGs} = {$urandom(), $urandom(), $urandom(), $urandom(),
			$urandom(), $urandom(), $urandom(), $urandom()};
		repeat (3) @(posedge core_clk);
		#1 rst = 0;
		for (int j = 0; j < 12; j++) qry(j < 5 ? j : $urandom_range(0, 5));
		segBaseNonZero = 4'h2;
		mode(1);
		ck("fault", 1, modeFault);
		segUsable = 4'hd;
		mode(1);
		ck("fs", tcsFs, fsOut);
		ck("gs", tcsGs, gsOut);
		ins = 1;
		mode(1);
		ck("load", 0, segLoad);
		acc(0, 52'h2000, 2, 0);
		acc(2, 52'h9000, 1, 0);
		mapsProtected = 1;
		mapR = 1;
		acc(0, 52'h2000, 0, 0);
		ck("class", 1, accClass);
		acc(1, 52'h2000, 2, 1);
		mapLinearMatch = 0;
		acc(0, 52'h2000, 2, 1);
		mapLinearMatch = 1;
		mapOwnerMatch = 0;
		acc(0, 52'h2000, 2, 1);
		mapOwnerMatch = 1;
		for (int j = 0; j < 4; j++) begin
			mapType = j == 0 ? 3'h0 : j == 1 ? 3'h1 : j == 2 ? 3'h3 : 3'h4;
			acc(0, 52'h2000, 2, 1);
		end
		mapType = 2;
		for (int j = 0; j < 3; j++) begin
			{mapBlocked, mapPending, mapModified} = 3'h4 >> j;
			acc(0, 52'h2000, 2, 1);
		end
		{mapBlocked, mapPending, mapModified} = 0;
		segFault = 1;
		acc(0, 52'h2000, 3, 0);
		segFault = 0;
		accIndirect = 1;
		acc(0, 52'h2000, 0, 0);
		ck("class", 2, accClass);
		accIndirect = 0;
		for (int j = 0; j < 8; j++) begin
			mapX = $urandom_range(0, 1);
			acc(2, rangeBase + $urandom_range(0, 32'h7fff), mapX ? 2'h0 : 2'h2, !mapX);
		end
		mode(4);
		ins = 0;
		ck("ssa", tcsFs, ssaFsOut);
		ck("ssags", tcsGs, ssaGsOut);
		ck("store", 1, ssaStore);
		ck("fsback", OFS, fsOut);
		ck("gsback", OGS, gsOut);
		acc(0, 52'h2000, 0, 0);
		ck("ones", 1, forceOnes);
		mode(3);
		ck("load", 0, segLoad);
		mode(2);
		ck("fsres", ssaFs, fsOut);
		mode(3);
		ck("fsleave", OFS, fsOut);
		ck("mode", 0, inEnclave);
		end_sim;
	end
endmodule
`default_nettype wire
